/* File: hdl/twm_pkg.sv */
package twm_pkg;
	// Register byte offsets on the APB window
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_BEGIN_READ  = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_BEGIN_WRITE = 12'h008;
	localparam logic [ADDR_W-1:0] OFS_STOP        = 12'h014;
	localparam logic [ADDR_W-1:0] OFS_EV_STOPPED  = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_EV_RXRDY    = 12'h108;
	localparam logic [ADDR_W-1:0] OFS_EV_TXSENT   = 12'h11c;
	localparam logic [ADDR_W-1:0] OFS_EV_ERROR    = 12'h124;
	localparam logic [ADDR_W-1:0] OFS_ENABLE      = 12'h500;
	localparam logic [ADDR_W-1:0] OFS_PSEL_SCL    = 12'h508;
	localparam logic [ADDR_W-1:0] OFS_PSEL_SDA    = 12'h50c;
	localparam logic [ADDR_W-1:0] OFS_RXD         = 12'h518;
	localparam logic [ADDR_W-1:0] OFS_TXD         = 12'h51c;
	localparam logic [ADDR_W-1:0] OFS_FREQ        = 12'h524;
	localparam logic [ADDR_W-1:0] OFS_ADDR        = 12'h588;

	// Field layout
	localparam int TASK_BIT      = 0;
	localparam int EVENT_BIT     = 0;
	localparam int ENABLE_BIT    = 0;
	localparam int FREQ_FAST_BIT = 0;
	localparam int PIN_W         = 5;
	localparam int PSEL_DISC_BIT = 31;

	// Reset values
	localparam logic             RST_DISC = 1'b1;
	localparam logic [PIN_W-1:0] RST_PIN  = 5'h1f;
	localparam logic [6:0]       RST_ADDR = 7'h00;

	// Bus timing, one quarter of an SCL period per divider tick
	localparam int SYS_CLK_HZ  = 100_000_000;
	localparam int SCL_STD_HZ  = 100_000;
	localparam int SCL_FAST_HZ = 400_000;
	localparam int QTR_STD     = (SYS_CLK_HZ + 4 * SCL_STD_HZ - 1) / (4 * SCL_STD_HZ);
	localparam int QTR_FAST    = (SYS_CLK_HZ + 4 * SCL_FAST_HZ - 1) / (4 * SCL_FAST_HZ);
	localparam logic [7:0] QTR_STD_M1  = 8'(QTR_STD - 1);
	localparam logic [7:0] QTR_FAST_M1 = 8'(QTR_FAST - 1);

	// Bus sequencer states, Gray along idle-start-low-high-stop
	typedef enum logic [2:0] {
		TWM_IDLE  = 3'h0,
		TWM_START = 3'h1,
		TWM_LOW   = 3'h3,
		TWM_HIGH  = 3'h2,
		TWM_STOP  = 3'h6
	} twm_phase_t;
endpackage

/* File: hdl/twm_line_if.sv */
`timescale 1ns/1ps
interface twm_line_if;
	logic raw;
	logic level;
	modport sync (input raw, output level);
	modport user (output raw, input level);
endinterface

/* File: hdl/twm_sync.sv */
`timescale 1ns/1ps
module twm_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input wire logic     sys_clk,
	input wire logic     resetn,
	twm_line_if.sync     line
);
	typedef struct packed {
		logic first;
		logic second;
	} twm_sync_t;

	twm_sync_t s_reg;
	twm_sync_t s_next;

	// First stage feeds only the second stage
	always_comb begin
		s_next.first  = line.raw;
		s_next.second = s_reg.first;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_reg <= '{first: IDLE_LEVEL, second: IDLE_LEVEL};
		end else begin
			s_reg <= s_next;
		end
	end

	assign line.level = s_reg.second;
endmodule

/* File: hdl/twm_master.sv */
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
// Function
// RULE_01 - SCL runs at 100 kHz or 400 kHz as selected.
// RULE_02 - Controller must be the only master on its bus.
// RULE_03 - A high SCL phase waits while a slave holds SCL low.
// RULE_04 - Write task: START, 7-bit address, direction bit 0.
// RULE_05 - Read task: START, address, direction bit 1.
// RULE_06 - Receiver answers each byte with one bit: low ACK, high NACK.
// RULE_07 - A NACK sampled from the slave raises the error event.
// RULE_08 - After address ACK, each written transmit byte is shifted out, then ACK sampled.
// RULE_09 - Byte-sent event after a byte and its ACK bit finish.
// RULE_10 - Software writes transmit byte only after the previous byte-sent event.
// RULE_11 - No new transmit byte: SCL is held low until one arrives.
// RULE_12 - Stop task during a write ends with a STOP condition.
// RULE_13 - Slave drives read bytes on SDA, timed by master SCL pulses.
// RULE_14 - Byte-received event when a new byte enters the receive register.
// RULE_15 - After a received byte, SCL held low until receive register is read.
// RULE_16 - Software triggers stop before reading the last received byte.
// RULE_17 - Pending stop at last read: answer NACK, then STOP.
// RULE_18 - SCL and SDA go to selected pins; disconnected reaches no pin.
// RULE_19 - Pin selection acts only while enabled.
// RULE_20 - Software changes pin selection only while disabled.
// RULE_21 - Both pins set up externally as standard-low open-high inputs.
// RULE_22 - Software disables sharing peripherals and programs every register.
// RULE_23 - Start task pending at last read: NACK, then repeated START.
// RULE_24 - Stopped event after the stop task completes.
// RULE_25 - START and STOP change SDA with SCL high; data changes with SCL low.
module twm_master #(
	parameter int NUM_PINS = 32
) (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [twm_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [NUM_PINS-1:0]         pin_in,
	output logic      [NUM_PINS-1:0]         pin_out,
	output logic      [NUM_PINS-1:0]         pin_oe,
	output logic                             stopped_event,
	output logic                             byte_received_event,
	output logic                             byte_sent_event,
	output logic                             error_event
);
	import twm_pkg::*;

	typedef struct packed {
		logic             enable;
		logic             freq_fast;
		logic             scl_disc;
		logic [PIN_W-1:0] scl_pin;
		logic             sda_disc;
		logic [PIN_W-1:0] sda_pin;
		logic [6:0]       addr;
		logic [7:0]       txd;
		logic             tx_full;
		logic [7:0]       rxd;
		logic             rx_full;
		logic             ev_stopped;
		logic             ev_rxrdy;
		logic             ev_txsent;
		logic             ev_error;
		logic             p_stopped;
		logic             p_rx;
		logic             p_tx;
		logic             p_err;
		logic [31:0]      prdata;
		logic [7:0]       tcnt;
		twm_phase_t       st;
		logic [1:0]       ph;
		logic [3:0]       bitn;
		logic [7:0]       shreg;
		logic             rd;
		logic             is_addr;
		logic             stop_pend;
		logic             restart_pend;
		logic             restart_rd;
		logic             nack_drv;
		logic             scl_oe;
		logic             sda_oe;
	} twm_state_t;

	twm_state_t r_reg;
	twm_state_t r_next;

	twm_line_if scl_line();
	twm_line_if sda_line();

	logic tick;
	logic acc_wr;
	logic acc_rd;
	logic go_wr;
	logic go_rd;
	logic go_stop;
	logic hit;
	logic scl_s;
	logic sda_s;
	logic scl_conn;
	logic sda_conn;

	// Pin selection only counts while enabled; out-of-range pins are treated as disconnected
	assign scl_conn = r_reg.enable && !r_reg.scl_disc && (int'(r_reg.scl_pin) < NUM_PINS); // [RULE_18] [RULE_19]
	assign sda_conn = r_reg.enable && !r_reg.sda_disc && (int'(r_reg.sda_pin) < NUM_PINS); // [RULE_18] [RULE_19]
	assign scl_line.raw = scl_conn ? pin_in[r_reg.scl_pin] : 1'b1;
	assign sda_line.raw = sda_conn ? pin_in[r_reg.sda_pin] : 1'b1;
	assign scl_s = scl_line.level;
	assign sda_s = sda_line.level;

	twm_sync u_scl_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.line    (scl_line)
	);

	twm_sync u_sda_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.line    (sda_line)
	);

	// Open drain: the pad only ever pulls low
	always_comb begin
		pin_out = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			pin_oe[i] = (scl_conn && int'(r_reg.scl_pin) == i && r_reg.scl_oe) ||
				(sda_conn && int'(r_reg.sda_pin) == i && r_reg.sda_oe); // [RULE_18]
		end
	end

	// APB decode, zero wait states
	always_comb begin
		unique case (paddr)
			OFS_BEGIN_READ, OFS_BEGIN_WRITE, OFS_STOP, OFS_EV_STOPPED, OFS_EV_RXRDY,
			OFS_EV_TXSENT, OFS_EV_ERROR, OFS_ENABLE, OFS_PSEL_SCL, OFS_PSEL_SDA,
			OFS_RXD, OFS_TXD, OFS_FREQ, OFS_ADDR: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign acc_wr  = psel && penable && pwrite && hit;
	assign acc_rd  = psel && penable && !pwrite && hit;
	assign go_wr   = acc_wr && paddr == OFS_BEGIN_WRITE && pwdata[TASK_BIT];
	assign go_rd   = acc_wr && paddr == OFS_BEGIN_READ && pwdata[TASK_BIT];
	assign go_stop = acc_wr && paddr == OFS_STOP && pwdata[TASK_BIT];
	assign tick    = r_reg.tcnt == 8'h00;

	// Registers, divider and bus sequencer; hardware sets come after software clears
	always_comb begin
		r_next = r_reg;
		r_next.p_stopped = 1'b0;
		r_next.p_rx = 1'b0;
		r_next.p_tx = 1'b0;
		r_next.p_err = 1'b0;
		r_next.tcnt = (tick || (r_reg.st == TWM_HIGH && !scl_s)) ? // Stretch restarts the count [RULE_03]
			(r_reg.freq_fast ? QTR_FAST_M1 : QTR_STD_M1) : r_reg.tcnt - 8'h01; // [RULE_01]
		// Read data is fetched in setup so it stands through the access phase
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				OFS_EV_STOPPED: r_next.prdata = {31'h0, r_reg.ev_stopped};
				OFS_EV_RXRDY:   r_next.prdata = {31'h0, r_reg.ev_rxrdy};
				OFS_EV_TXSENT:  r_next.prdata = {31'h0, r_reg.ev_txsent};
				OFS_EV_ERROR:   r_next.prdata = {31'h0, r_reg.ev_error};
				OFS_ENABLE:     r_next.prdata = {31'h0, r_reg.enable};
				OFS_PSEL_SCL:   r_next.prdata = {r_reg.scl_disc, 26'h0, r_reg.scl_pin};
				OFS_PSEL_SDA:   r_next.prdata = {r_reg.sda_disc, 26'h0, r_reg.sda_pin};
				OFS_RXD:        r_next.prdata = {24'h0, r_reg.rxd};
				OFS_TXD:        r_next.prdata = {24'h0, r_reg.txd};
				OFS_FREQ:       r_next.prdata = {31'h0, r_reg.freq_fast};
				OFS_ADDR:       r_next.prdata = {25'h0, r_reg.addr};
				default:        r_next.prdata = 32'h0;
			endcase
		end
		if (acc_rd && paddr == OFS_RXD) begin
			r_next.rx_full = 1'b0;
		end
		if (acc_wr) begin
			unique case (paddr)
				OFS_EV_STOPPED: if (!pwdata[EVENT_BIT]) r_next.ev_stopped = 1'b0;
				OFS_EV_RXRDY:   if (!pwdata[EVENT_BIT]) r_next.ev_rxrdy = 1'b0;
				OFS_EV_TXSENT:  if (!pwdata[EVENT_BIT]) r_next.ev_txsent = 1'b0;
				OFS_EV_ERROR:   if (!pwdata[EVENT_BIT]) r_next.ev_error = 1'b0;
				OFS_ENABLE:     r_next.enable = pwdata[ENABLE_BIT];
				OFS_PSEL_SCL:   {r_next.scl_disc, r_next.scl_pin} = {pwdata[PSEL_DISC_BIT], pwdata[PIN_W-1:0]};
				OFS_PSEL_SDA:   {r_next.sda_disc, r_next.sda_pin} = {pwdata[PSEL_DISC_BIT], pwdata[PIN_W-1:0]};
				OFS_FREQ:       r_next.freq_fast = pwdata[FREQ_FAST_BIT];
				OFS_ADDR:       r_next.addr = pwdata[6:0];
				OFS_TXD: begin
					r_next.txd = pwdata[7:0];
					r_next.tx_full = 1'b1;
				end
				default: ;
			endcase
		end
		// Tasks arriving mid-transfer are remembered until a byte boundary
		if (r_reg.st != TWM_IDLE) begin
			if (go_stop) r_next.stop_pend = 1'b1;
			if (go_wr || go_rd) begin
				r_next.restart_pend = 1'b1;
				r_next.restart_rd = go_rd;
			end
		end
		if (!r_reg.enable) begin
			r_next.st = TWM_IDLE;
			r_next.scl_oe = 1'b0;
			r_next.sda_oe = 1'b0;
			r_next.stop_pend = 1'b0;
			r_next.restart_pend = 1'b0;
		end else begin
			unique case (r_reg.st)
				TWM_IDLE: begin
					r_next.scl_oe = 1'b0;
					r_next.sda_oe = 1'b0;
					if (go_wr || go_rd) begin
						r_next.rd = go_rd;
						r_next.st = TWM_START;
						r_next.ph = 2'h0;
					end else if (go_stop) begin
						r_next.ev_stopped = 1'b1; // [RULE_24]
						r_next.p_stopped = 1'b1;
					end
				end
				TWM_START: if (tick) begin
					unique case (r_reg.ph)
						2'h0: begin
							r_next.sda_oe = 1'b0;
							r_next.ph = 2'h1;
						end
						2'h1: begin
							r_next.scl_oe = 1'b0;
							r_next.ph = 2'h2;
						end
						2'h2: if (scl_s) begin
							r_next.sda_oe = 1'b1; // [RULE_25]
							r_next.ph = 2'h3;
						end
						default: begin
							r_next.scl_oe = 1'b1;
							r_next.st = TWM_LOW;
							r_next.ph = 2'h0;
							r_next.bitn = 4'h0;
							r_next.is_addr = 1'b1;
							r_next.restart_pend = 1'b0;
							r_next.shreg = {r_reg.addr, r_reg.rd}; // [RULE_04] [RULE_05]
						end
					endcase
				end
				TWM_LOW: if (tick) begin
					if (r_reg.ph == 2'h1) begin
						r_next.scl_oe = 1'b0;
						r_next.st = TWM_HIGH;
						r_next.ph = 2'h0;
					end else if (r_reg.bitn == 4'h0 && !r_reg.is_addr && r_reg.stop_pend &&
						(!r_reg.rd || r_reg.nack_drv)) begin
						r_next.st = TWM_STOP; // [RULE_12] [RULE_17]
					end else if (r_reg.bitn == 4'h0 && !r_reg.is_addr && r_reg.restart_pend &&
						(!r_reg.rd || r_reg.nack_drv)) begin
						r_next.st = TWM_START; // [RULE_23]
						r_next.rd = r_reg.restart_rd;
					end else if (r_reg.bitn == 4'h0 && !r_reg.is_addr && !r_reg.rd) begin
						// Nothing to send keeps SCL low, which paces software
						if (r_reg.tx_full) begin
							r_next.shreg = r_reg.txd; // [RULE_08]
							r_next.tx_full = 1'b0;
							r_next.sda_oe = !r_reg.txd[7];
							r_next.ph = 2'h1;
						end // [RULE_11]
					end else if (r_reg.bitn == 4'h8 && r_reg.rd && !r_reg.is_addr) begin
						if (!r_reg.rx_full) begin // [RULE_15]
							r_next.nack_drv = r_reg.stop_pend || r_reg.restart_pend; // [RULE_17] [RULE_23]
							r_next.sda_oe = !(r_reg.stop_pend || r_reg.restart_pend); // [RULE_06]
							r_next.ph = 2'h1;
						end
					end else if (r_reg.bitn == 4'h8 || (r_reg.rd && !r_reg.is_addr)) begin
						r_next.sda_oe = 1'b0; // [RULE_06] [RULE_13]
						r_next.ph = 2'h1;
					end else begin
						r_next.sda_oe = !r_reg.shreg[7]; // [RULE_25]
						r_next.ph = 2'h1;
					end
				end
				TWM_HIGH: if (tick && scl_s) begin // [RULE_03]
					if (r_reg.ph == 2'h0) begin
						r_next.ph = 2'h1;
						if (r_reg.bitn != 4'h8) begin
							r_next.shreg = {r_reg.shreg[6:0], sda_s};
						end else if (!r_reg.rd || r_reg.is_addr) begin
							r_next.nack_drv = sda_s;
							if (sda_s) begin
								r_next.ev_error = 1'b1; // [RULE_07]
								r_next.p_err = 1'b1;
							end
						end
					end else begin
						r_next.scl_oe = 1'b1;
						r_next.st = TWM_LOW;
						r_next.ph = 2'h0;
						if (r_reg.bitn == 4'h8) begin
							r_next.bitn = 4'h0;
							r_next.is_addr = 1'b0;
							if (!r_reg.rd && !r_reg.is_addr) begin
								r_next.ev_txsent = 1'b1; // [RULE_09]
								r_next.p_tx = 1'b1;
							end
						end else begin
							r_next.bitn = r_reg.bitn + 4'h1;
							if (r_reg.bitn == 4'h7 && r_reg.rd && !r_reg.is_addr) begin
								r_next.rxd = r_reg.shreg; // [RULE_14]
								r_next.rx_full = 1'b1;
								r_next.ev_rxrdy = 1'b1;
								r_next.p_rx = 1'b1;
							end
						end
					end
				end
				TWM_STOP: if (tick) begin
					unique case (r_reg.ph)
						2'h0: begin
							r_next.scl_oe = 1'b1;
							r_next.sda_oe = 1'b1;
							r_next.ph = 2'h1;
						end
						2'h1: begin
							r_next.scl_oe = 1'b0;
							r_next.ph = 2'h2;
						end
						default: if (scl_s) begin
							r_next.sda_oe = 1'b0; // [RULE_25]
							r_next.st = TWM_IDLE;
							r_next.ph = 2'h0;
							r_next.stop_pend = 1'b0;
							r_next.restart_pend = 1'b0;
							r_next.ev_stopped = 1'b1; // [RULE_24]
							r_next.p_stopped = 1'b1;
						end
					endcase
				end
				default: r_next.st = TWM_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r_reg <= '0;
			r_reg.scl_disc <= RST_DISC;
			r_reg.sda_disc <= RST_DISC;
			r_reg.scl_pin <= RST_PIN;
			r_reg.sda_pin <= RST_PIN;
			r_reg.addr <= RST_ADDR;
			r_reg.st <= TWM_IDLE;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata              = r_reg.prdata;
	assign stopped_event       = r_reg.p_stopped;
	assign byte_received_event = r_reg.p_rx;
	assign byte_sent_event     = r_reg.p_tx;
	assign error_event         = r_reg.p_err;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_tick_spacing: assert property (tick |=> !tick [*8]) else $error("divider tick too frequent"); // [RULE_01]
	a_scl_stretch: assert property (r_reg.st == TWM_HIGH && !scl_s |=> // [RULE_03]
		r_reg.st == TWM_HIGH && !r_reg.scl_oe) else $error("high phase ended while SCL was held low");
	a_addr_dir: assert property ($past(r_reg.st) == TWM_START && r_reg.st == TWM_LOW // [RULE_04]
		|-> r_reg.shreg == {r_reg.addr, r_reg.rd}) else $error("address byte wrong");
	a_nack_error: assert property (r_reg.st == TWM_HIGH && r_reg.ph == 2'h0 && tick && scl_s && // [RULE_07]
		r_reg.bitn == 4'h8 && !r_reg.rd && sda_s |=> r_reg.ev_error && error_event)
		else $error("slave NACK did not flag error");
	a_txsent_cause: assert property ($rose(byte_sent_event) |-> $past(r_reg.st) == TWM_HIGH && // [RULE_09]
		$past(r_reg.bitn) == 4'h8 && r_reg.st == TWM_LOW) else $error("byte sent at wrong time");
	a_tx_hold: assert property (r_reg.st == TWM_LOW && r_reg.ph == 2'h0 && r_reg.bitn == 4'h0 && // [RULE_11]
		!r_reg.is_addr && !r_reg.rd && !r_reg.tx_full && !r_reg.stop_pend && !r_reg.restart_pend
		|=> r_reg.st == TWM_LOW && r_reg.scl_oe) else $error("SCL released with no byte");
	a_rx_hold: assert property (r_reg.st == TWM_LOW && r_reg.bitn == 4'h8 && r_reg.rd && // [RULE_15]
		!r_reg.is_addr && r_reg.rx_full |=> r_reg.st == TWM_LOW)
		else $error("ack sent before receive register read");
	a_stop_nack: assert property (r_reg.st == TWM_LOW && r_reg.ph == 2'h0 && tick && r_reg.bitn == 4'h8 && // [RULE_17]
		r_reg.rd && !r_reg.is_addr && !r_reg.rx_full && r_reg.stop_pend |=> !r_reg.sda_oe && r_reg.nack_drv)
		else $error("last byte not NACKed");
	a_pins_off: assert property (!r_reg.enable |-> pin_oe == '0) else $error("pin driven while disabled"); // [RULE_19]
	a_sda_stable: assert property (r_reg.st == TWM_HIGH && $past(r_reg.st) == TWM_HIGH // [RULE_25]
		|-> $stable(r_reg.sda_oe)) else $error("SDA moved while SCL high");
	a_stop_event: assert property (r_reg.st == TWM_STOP && r_reg.ph == 2'h2 && tick && scl_s // [RULE_24]
		|=> stopped_event && r_reg.st == TWM_IDLE) else $error("stop not completed");

	c_byte_sent: cover property (byte_sent_event);
	c_byte_recv: cover property (byte_received_event);
	c_stop_done: cover property (r_reg.st == TWM_STOP ##1 r_reg.st == TWM_IDLE);
	c_nack: cover property (error_event);
endmodule

/* File: sim/twm_slave.sv */
`timescale 1ns/1ps
// Behavioural bus slave; only ever pulls lines low, the pull-ups do the rest
module twm_slave #(
	parameter logic [6:0] DEV_ADDR = 7'h5a,
	parameter logic [7:0] FIRST_TX = 8'hc3
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic stretch,
	output logic      scl_pull,
	output logic      sda_pull,
	output logic [7:0] last_byte,
	output int        n_bytes,
	output int        n_stop,
	output logic      master_ack
);
	logic       in_frame, addr_phase, reading;
	logic [7:0] shreg, txbyte;
	int         bitc;

	initial begin
		{scl_pull, sda_pull, in_frame, addr_phase, reading} = 5'h0;
		n_bytes = 0;
		n_stop = 0;
		bitc = 0;
	end

	// Start: data falls while clock high
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			in_frame = 1'b1;
			addr_phase = 1'b1;
			reading = 1'b0;
			bitc = 0;
			txbyte = FIRST_TX;
		end
	end

	// Stop: data rises while clock high; counted only inside a frame
	always @(posedge sda) begin
		if (scl === 1'b1 && in_frame) begin
			in_frame = 1'b0;
			n_stop++;
		end
	end

	// Bits and the master's answer are taken on the rising clock
	always @(posedge scl) begin
		if (in_frame) begin
			if (bitc < 8)
				shreg = {shreg[6:0], sda};
			if (bitc == 8 && reading && !addr_phase)
				master_ack = sda;
			bitc++;
		end
	end

	// Data changes only while the clock is low
	always @(negedge scl) begin
		if (in_frame) begin
			if (bitc == 8) begin
				if (addr_phase || !reading) begin
					last_byte = shreg;
					n_bytes++;
					sda_pull = !addr_phase || shreg[7:1] == DEV_ADDR;
					reading = addr_phase && shreg[7:1] == DEV_ADDR && shreg[0];
				end else
					sda_pull = 1'b0;
			end else if (bitc == 9) begin
				bitc = 0;
				// A master NACK ends our sending; bus is released for stop
				if (reading && (addr_phase || !master_ack)) begin
					if (!addr_phase)
						txbyte--;
				end else
					reading = 1'b0;
				addr_phase = 1'b0;
				sda_pull = reading && !txbyte[7];
			end else
				sda_pull = reading && !addr_phase && !txbyte[7-bitc];
		end
		// Longer than a fast-mode low half, so the master must wait for us
		if (stretch) begin
			scl_pull = 1'b1;
			#2000 scl_pull = 1'b0;
		end
	end
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
	import twm_pkg::*;
	logic              sys_clk, resetn, psel, penable, pwrite, stretch;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, pin_in, pin_out, pin_oe, rdata;
	logic              pready, pslverr, rerr, scl_w, sda_w, scl_pull, sda_pull, m_ack;
	logic              stopped_event, byte_received_event, byte_sent_event, error_event;
	logic [7:0]        s_byte;
	int                errors, n_compared, s_bytes, s_stops, ev[4];
	realtime           t_rise, t_prev, t_high;

	twm_master twm_master_i (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .pin_in, .pin_out, .pin_oe, .stopped_event, .byte_received_event,
		.byte_sent_event, .error_event);
	// The model only answers as a slave, so the block stays the one master
	twm_slave twm_slave_i (.scl(scl_w), .sda(sda_w), .stretch, .scl_pull, .sda_pull,
		.last_byte(s_byte), .n_bytes(s_bytes), .n_stop(s_stops), .master_ack(m_ack));

	// Open-drain wires with pull-ups; SCL on pin 3, SDA on pin 4
	assign scl_w = !(pin_oe[3] || scl_pull);
	assign sda_w = !(pin_oe[4] || sda_pull);
	assign pin_in = {~pin_oe[31:5], sda_w, scl_w, ~pin_oe[2:0]};

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Event pulses last one cycle, so count them here
	always @(posedge sys_clk) begin
		ev[0] <= ev[0] + int'(stopped_event === 1'b1);
		ev[1] <= ev[1] + int'(byte_received_event === 1'b1);
		ev[2] <= ev[2] + int'(byte_sent_event === 1'b1);
		ev[3] <= ev[3] + int'(error_event === 1'b1);
	end

	// Clock timing seen on the wire
	always @(posedge scl_w) begin
		t_prev = t_rise;
		t_rise = $realtime;
	end
	always @(negedge scl_w)
		t_high = $realtime - t_rise;

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the idle cycle after it keeps psel from toggling twice
	task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1)
			@(posedge sys_clk);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task rd(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, rdata, exp);
	endtask

	// Index 0..3 waits on an event count, 4 on bytes taken by the slave
	task wait_for(input int i, input int target);
		int k;
		k = 0;
		while ((i < 4 ? ev[i] : s_bytes) < target && k < 30000) begin
			@(posedge sys_clk);
			k++;
		end
		// A wait that runs out is a failure of its own
		if (k >= 30000) begin
			errors++;
			results();
		end
	endtask

	task results();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial begin
		#900_000;
		errors++;
		$display("Timeout waiting for the bus");
		results();
	end

	initial begin
		{resetn, psel, penable, pwrite, stretch} = 5'h0;
		paddr = '0;
		pwdata = 32'h0;
		ev = '{default: 0};
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		@(posedge sys_clk);
		// Reset state and an unmapped address
		rd("scl pin select", OFS_PSEL_SCL, 32'h8000001f);
		rd("enable", OFS_ENABLE, 32'h0);
		apb(1'b0, 12'h010, 32'h0);
		check("unmapped error", 32'(rerr), 32'h1);
		check("pins idle", pin_oe, 32'h0);
		// Every setting, fast mode included, written while disabled, then enable
		apb(1'b1, OFS_PSEL_SCL, 32'h3);
		apb(1'b1, OFS_PSEL_SDA, 32'h4);
		apb(1'b1, OFS_FREQ, 32'h1);
		apb(1'b1, OFS_ADDR, 32'h5a);
		apb(1'b1, OFS_ENABLE, 32'h1);
		// Write: no byte supplied yet, so the clock must stay low
		apb(1'b1, OFS_BEGIN_WRITE, 32'h1);
		wait_for(4, 1);
		repeat (1500) @(posedge sys_clk);
		check("address byte", 32'(s_byte), 32'hb4);
		check("scl held", 32'(scl_w), 32'h0);
		apb(1'b1, OFS_TXD, 32'ha5);
		wait_for(2, 1);
		check("sent count", 32'(ev[2]), 32'h1);
		check("data byte", 32'(s_byte), 32'ha5);
		check("fast period", 32'(t_rise - t_prev > 2500.0 && t_rise - t_prev < 2600.0), 32'h1);
		rd("sent flag", OFS_EV_TXSENT, 32'h1);
		apb(1'b1, OFS_EV_TXSENT, 32'h0);
		rd("sent cleared", OFS_EV_TXSENT, 32'h0);
		apb(1'b1, OFS_STOP, 32'h1);
		wait_for(0, 1);
		check("stopped count", 32'(ev[0]), 32'h1);
		check("stop on bus", 32'(s_stops), 32'h1);
		// Nobody answers this address
		apb(1'b1, OFS_ADDR, 32'h11);
		apb(1'b1, OFS_BEGIN_WRITE, 32'h1);
		wait_for(3, 1);
		check("error count", 32'(ev[3]), 32'h1);
		apb(1'b1, OFS_STOP, 32'h1);
		wait_for(0, 2);
		check("stop after nack", 32'(s_stops), 32'h2);
		// Read with a stretching slave
		apb(1'b1, OFS_ADDR, 32'h5a);
		stretch <= 1'b1;
		apb(1'b1, OFS_BEGIN_READ, 32'h1);
		wait_for(1, 1);
		check("read address", 32'(s_byte), 32'hb5);
		check("high half kept", 32'(t_high > 1250.0), 32'h1);
		repeat (1000) @(posedge sys_clk);
		check("scl held rx", 32'(scl_w), 32'h0);
		rd("first byte", OFS_RXD, 32'hc3);
		wait_for(1, 2);
		check("master ack", 32'(m_ack), 32'h0);
		apb(1'b1, OFS_STOP, 32'h1);
		rd("last byte", OFS_RXD, 32'hc2);
		wait_for(0, 3);
		check("master nack", 32'(m_ack), 32'h1);
		check("stop after read", 32'(s_stops), 32'h3);
		// Standard rate: one byte read, then a repeated start into a write
		stretch <= 1'b0;
		apb(1'b1, OFS_FREQ, 32'h0);
		apb(1'b1, OFS_BEGIN_READ, 32'h1);
		wait_for(1, 3);
		check("std period", 32'(t_rise - t_prev > 9900.0 && t_rise - t_prev < 10100.0), 32'h1);
		apb(1'b1, OFS_BEGIN_WRITE, 32'h1);
		rd("restart byte", OFS_RXD, 32'hc3);
		wait_for(4, 6);
		check("restart nack", 32'(m_ack), 32'h1);
		check("restart address", 32'(s_byte), 32'hb4);
		check("no stop between", 32'(s_stops), 32'h3);
		apb(1'b1, OFS_STOP, 32'h1);
		wait_for(0, 4);
		check("stop after restart", 32'(s_stops), 32'h4);
		apb(1'b1, OFS_ENABLE, 32'h0);
		check("pins released", pin_oe, 32'h0);
		check("open drain", pin_out, 32'h0);
		results();
	end
endmodule
